// [design/fsal_outputs.sv]
/*
  Fault alarm and input loss status outputs of a motor drive: latched
  trip flag, delayed alarm, input loss detection, selectable functions on
  two open-collector outputs and the alarm relay, relay polarity with a
  power-up hold-off in normally closed use, minimum frequency clamp and a small register file.
  Assumes one 25 MHz clock, synchronous inputs, single-cycle bus strobes.
*/
`timescale 1ns/1ps
module fsal_outputs #(
  parameter int unsigned REF_W = 10,
  parameter int unsigned IREF_W = 12,
  parameter int unsigned ALARM_DELAY_CYC = fsal_pkg::ALARM_DELAY_CYC,
  parameter int unsigned POWERUP_CYC = fsal_pkg::POWERUP_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic trip_event,
  input wire logic fault_clear,
  input wire logic run_mode,
  input wire logic [REF_W-1:0] vref_input,
  input wire logic [IREF_W-1:0] iref_input,
  input wire logic [REF_W-1:0] freq_ref_in,
  output logic oc_out1_n,
  output logic oc_out2_n,
  output logic relay_energize,
  output logic decel_stop_req,
  output logic [REF_W-1:0] freq_cmd,
  output logic irq
);
  import fsal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic relay_polarity_setting;
    logic [3:0] fsel_oc1;
    logic [3:0] fsel_oc2;
    logic [3:0] relay_function_select;
    logic [1:0] freq_source_select;
    logic [REF_W-1:0] start_freq_adjust;
    logic trip_flag;
    logic loss_prev;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic oc1_n;
    logic oc2_n;
    logic relay;
    logic decel;
    logic [REF_W-1:0] freq_cmd;
    logic irq;
  } fsal_state_t;

  fsal_state_t s_q;
  fsal_state_t s_d;

  logic alarm_dly;
  logic pwr_ok;
  logic vloss;
  logic iloss;
  logic input_loss_flag;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic f_oc1;
  logic f_oc2;
  logic f_rly;

  function automatic logic fsal_func(input logic [3:0] code, input logic alarm,
                                     input logic loss);
    logic r;
    r = 1'b0;
    if (code == FUNC_ALARM) begin
      r = alarm;
    end else if (code == FUNC_LOSS) begin
      r = loss;
    end
    return r;
  endfunction : fsal_func

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Alarm delayed before it reaches any output pin
  fsal_level_delay #(.CYC(ALARM_DELAY_CYC)) u_alarm_dly (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .level_in(s_q.trip_flag),
    .level_out(alarm_dly)
  );

  // Power-up hold-off: a constant high seen through the delay line
  fsal_level_delay #(.CYC(POWERUP_CYC)) u_pwr_dly (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .level_in(1'b1),
    .level_out(pwr_ok)
  );

  fsal_loss_detect #(.REF_W(REF_W), .IREF_W(IREF_W)) u_loss (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .vref_input(vref_input),
    .iref_input(iref_input),
    .start_freq_adjust(s_q.start_freq_adjust),
    .vloss(vloss),
    .iloss(iloss),
    .input_loss_flag(input_loss_flag)
  );

  // ----------------------------------------------------------------
  // Readback words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_POL_BIT] = s_q.relay_polarity_setting;
    ctrl_word[CTRL_OC1_LSB +: 4] = s_q.fsel_oc1;
    ctrl_word[CTRL_OC2_LSB +: 4] = s_q.fsel_oc2;
    ctrl_word[CTRL_RLY_LSB +: 4] = s_q.relay_function_select;
    ctrl_word[CTRL_SRC_LSB +: 2] = s_q.freq_source_select;
    status_word = '0;
    status_word[ST_TRIP] = s_q.trip_flag;
    status_word[ST_ALARM] = alarm_dly;
    status_word[ST_LOSS] = input_loss_flag;
    status_word[ST_VLOSS] = vloss;
    status_word[ST_ILOSS] = iloss;
    status_word[ST_PWR] = pwr_ok;
    status_word[ST_RELAY] = s_q.relay;
  end

  assign f_oc1 = fsal_func(s_q.fsel_oc1, alarm_dly, input_loss_flag);
  assign f_oc2 = fsal_func(s_q.fsel_oc2, alarm_dly, input_loss_flag);
  assign f_rly = fsal_func(s_q.relay_function_select, alarm_dly, input_loss_flag);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // Read data stands for exactly one cycle
      s_d.rdata = '0;
      if (reg_rd) begin
        if (reg_addr == OFF_CTRL) begin
          s_d.rdata = ctrl_word;
        end else if (reg_addr == OFF_START) begin
          s_d.rdata = 32'(s_q.start_freq_adjust);
        end else if (reg_addr == OFF_STATUS) begin
          s_d.rdata = status_word;
        end else if (reg_addr == OFF_IRQ_STAT) begin
          s_d.rdata = 32'(s_q.irq_stat);
        end else if (reg_addr == OFF_IRQ_MASK) begin
          s_d.rdata = 32'(s_q.irq_mask);
        end else if (reg_addr == OFF_FREQ) begin
          s_d.rdata = 32'(s_q.freq_cmd);
        end
      end
      if (reg_wr) begin
        if (reg_addr == OFF_CTRL) begin
          s_d.relay_polarity_setting = reg_wdata[CTRL_POL_BIT];
          s_d.fsel_oc1 = reg_wdata[CTRL_OC1_LSB +: 4];
          s_d.fsel_oc2 = reg_wdata[CTRL_OC2_LSB +: 4];
          s_d.relay_function_select = reg_wdata[CTRL_RLY_LSB +: 4];
          s_d.freq_source_select = reg_wdata[CTRL_SRC_LSB +: 2];
        end else if (reg_addr == OFF_START) begin
          s_d.start_freq_adjust = reg_wdata[REF_W-1:0];
        end else if (reg_addr == OFF_IRQ_STAT) begin
          s_d.irq_stat = s_q.irq_stat & ~reg_wdata[1:0];
        end else if (reg_addr == OFF_IRQ_MASK) begin
          s_d.irq_mask = reg_wdata[1:0];
        end
      end

      // Latched flag; a trip in the clearing cycle keeps it set
      if (trip_event) begin
        s_d.trip_flag = 1'b1;
      end else if (fault_clear) begin
        s_d.trip_flag = 1'b0;
      end

      // Events applied after the clear so the set wins
      s_d.loss_prev = input_loss_flag;
      if (trip_event && !s_q.trip_flag) begin
        s_d.irq_stat[IRQ_TRIP] = 1'b1;
      end
      if (input_loss_flag && !s_q.loss_prev) begin
        s_d.irq_stat[IRQ_LOSS] = 1'b1;
      end
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

      s_d.oc1_n = !f_oc1;
      s_d.oc2_n = !f_oc2;
      // Unpowered relay reads as alarm in normally closed use
      if (s_q.relay_polarity_setting == POL_NC) begin
        s_d.relay = pwr_ok && !f_rly;
      end else begin
        s_d.relay = f_rly;
      end

      // Loss is not gated by run mode; only the stop request is
      s_d.decel = input_loss_flag && run_mode
                  && s_q.freq_source_select == SRC_ANALOG;
      if (freq_ref_in == '0) begin
        s_d.freq_cmd = '0;
      end else if (freq_ref_in < s_q.start_freq_adjust) begin
        s_d.freq_cmd = s_q.start_freq_adjust;
      end else begin
        s_d.freq_cmd = freq_ref_in;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.relay_polarity_setting <= RST_POL;
      s_q.fsel_oc1 <= RST_FSEL_OC1;
      s_q.fsel_oc2 <= RST_FSEL_OC2;
      s_q.relay_function_select <= RST_FSEL_RLY;
      s_q.freq_source_select <= RST_SRC;
      s_q.irq_mask <= RST_IRQ_MASK;
      s_q.oc1_n <= 1'b1;
      s_q.oc2_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign oc_out1_n = s_q.oc1_n;
  assign oc_out2_n = s_q.oc2_n;
  assign relay_energize = s_q.relay;
  assign decel_stop_req = s_q.decel;
  assign freq_cmd = s_q.freq_cmd;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_trip_in;
    ce && trip_event;
  endsequence

  sequence s_clear_only;
    ce && fault_clear && !trip_event;
  endsequence

  trip_set_a: assert property (s_trip_in |=> s_q.trip_flag)
    else $error("trip did not set the trip flag");

  trip_clear_a: assert property (s_clear_only |=> !s_q.trip_flag)
    else $error("fault clear did not drop the trip flag");

  trip_latch_a: assert property ((!ce || (!trip_event && !fault_clear))
    |=> $stable(s_q.trip_flag))
    else $error("trip flag moved without trip or clear");

  route_oc1_a: assert property ((ce && s_q.fsel_oc1 == FUNC_ALARM)
    |=> oc_out1_n == !$past(alarm_dly))
    else $error("alarm not routed to first output");

  route_loss_a: assert property ((ce && s_q.fsel_oc2 == FUNC_LOSS)
    |=> oc_out2_n == !$past(input_loss_flag))
    else $error("loss not routed active low to second output");

  relay_nc_a: assert property ((ce && s_q.relay_polarity_setting &&
    s_q.relay_function_select == FUNC_ALARM) |=> relay_energize == ($past(pwr_ok) && !$past(alarm_dly)))
    else $error("normally closed relay state wrong");

  powerup_hold_a: assert property ((ce && !pwr_ok) |=> !relay_energize)
    else $error("relay energized before power-up delay");

  relay_no_a: assert property ((ce && !s_q.relay_polarity_setting &&
    s_q.relay_function_select == FUNC_ALARM) |=> relay_energize == $past(alarm_dly))
    else $error("normally open relay state wrong");

  decel_a: assert property ((ce && input_loss_flag && run_mode &&
    s_q.freq_source_select == SRC_ANALOG) |=> decel_stop_req)
    else $error("loss did not request a stop ramp");

  min_freq_a: assert property ((ce && freq_ref_in != '0)
    |=> freq_cmd >= $past(s_q.start_freq_adjust) && freq_cmd != '0)
    else $error("command below start frequency");

  stop_loss_a: assert property ((ce && input_loss_flag && !run_mode &&
    s_q.fsel_oc2 == FUNC_LOSS) |=> !oc_out2_n)
    else $error("loss not reported in stop mode");

  rd_once_a: assert property ((ce && !reg_rd) |=> reg_rdata == '0)
    else $error("read data stood past its cycle");

endmodule : fsal_outputs

// [shared/fsal_pkg.sv]
/*
  Shared constants of the fault alarm and input loss output block:
  register offsets, field positions, reset values, function codes, timing.
  Assumes a 25 MHz system clock and a 32-bit plain register port.
*/
package fsal_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned ALARM_DELAY_MS = 300;
  localparam int unsigned ALARM_DELAY_CYC = ALARM_DELAY_MS * CYC_PER_MS;
  localparam int unsigned POWERUP_MAX_MS = 2000;
  // Strictly under the ceiling, counting the relay register's own cycle
  localparam int unsigned POWERUP_CYC = POWERUP_MAX_MS * CYC_PER_MS - 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_START = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_FREQ = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_POL_BIT = 0;
  localparam int unsigned CTRL_OC1_LSB = 4;
  localparam int unsigned CTRL_OC2_LSB = 8;
  localparam int unsigned CTRL_RLY_LSB = 12;
  localparam int unsigned CTRL_SRC_LSB = 16;
  localparam int unsigned ST_TRIP = 0;
  localparam int unsigned ST_ALARM = 1;
  localparam int unsigned ST_LOSS = 2;
  localparam int unsigned ST_VLOSS = 3;
  localparam int unsigned ST_ILOSS = 4;
  localparam int unsigned ST_PWR = 5;
  localparam int unsigned ST_RELAY = 6;
  localparam int unsigned IRQ_TRIP = 0;
  localparam int unsigned IRQ_LOSS = 1;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FUNC_ALARM = 4'h5;
  localparam logic [3:0] FUNC_LOSS = 4'h6;
  localparam logic POL_NC = 1'b1;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic RST_POL = POL_NC;
  localparam logic [3:0] RST_FSEL_OC1 = 4'h0;
  localparam logic [3:0] RST_FSEL_OC2 = 4'h0;
  localparam logic [3:0] RST_FSEL_RLY = FUNC_ALARM;
  localparam logic [1:0] RST_SRC = SRC_ANALOG;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  // Current input code at 4 mA on a 12-bit, 20 mA full-scale converter
  localparam logic [11:0] IREF_4MA_CODE = 12'h333;

endpackage : fsal_pkg

// [design/fsal_level_delay.sv]
/*
  Level delay: the output takes a new input level only after the input
  has differed from it for CYC enabled clock cycles.
  Assumes the input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module fsal_level_delay #(
  parameter int unsigned CYC = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic level_in,
  output logic level_out
);
  import fsal_pkg::*;

  localparam int unsigned CW = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic out;
    logic [CW-1:0] cnt;
  } fsal_dly_t;

  fsal_dly_t s_q;
  fsal_dly_t s_d;

  // Glitches shorter than the delay restart the count and never pass
  always_comb begin
    s_d = s_q;
    if (ce) begin
      if (level_in == s_q.out) begin
        s_d.cnt = '0;
      end else if (s_q.cnt == LAST) begin
        s_d.out = level_in;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.out;

  dly_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!ce || s_q.cnt != LAST) |=> $stable(level_out))
    else $error("delayed level moved before its count ran out");

  dly_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && s_q.cnt == LAST && level_in != level_out) |=> level_out == $past(level_in))
    else $error("delayed level did not follow after full count");

endmodule : fsal_level_delay

// [design/fsal_loss_detect.sv]
/*
  Analog reference loss detection: voltage reference below the start
  frequency setting, or current reference below the 4 mA code.
  Assumes both converter codes are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module fsal_loss_detect #(
  parameter int unsigned REF_W = 10,
  parameter int unsigned IREF_W = 12,
  parameter logic [IREF_W-1:0] IREF_MIN = fsal_pkg::IREF_4MA_CODE
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [REF_W-1:0] vref_input,
  input wire logic [IREF_W-1:0] iref_input,
  input wire logic [REF_W-1:0] start_freq_adjust,
  output logic vloss,
  output logic iloss,
  output logic input_loss_flag
);
  import fsal_pkg::*;

  typedef struct packed {
    logic v;
    logic i;
    logic any;
  } fsal_loss_t;

  fsal_loss_t s_q;
  fsal_loss_t s_d;

  // Pure level, no latch: clears by itself once the input recovers
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.v = vref_input < start_freq_adjust;
      s_d.i = iref_input < IREF_MIN;
      s_d.any = s_d.v | s_d.i;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign vloss = s_q.v;
  assign iloss = s_q.i;
  assign input_loss_flag = s_q.any;

  loss_volt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && vref_input < start_freq_adjust) |=> input_loss_flag && vloss)
    else $error("voltage reference loss not flagged");

  loss_curr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && iref_input < IREF_MIN) |=> input_loss_flag && iloss)
    else $error("current reference loss not flagged");

  loss_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && vref_input >= start_freq_adjust && iref_input >= IREF_MIN) |=> !input_loss_flag)
    else $error("loss flag did not clear on recovery");

endmodule : fsal_loss_detect

// [verification/fsal_alarm_loop.sv]
/*
  External alarm loop model: watches the relay coil drive through the
  contact pair that the polarity setting wires in.
  Assumes a closed loop means no alarm, so a broken wire also alarms.
*/
`timescale 1ns/1ps
module fsal_alarm_loop (
  input wire logic relay_energize,
  input wire logic pol_nc,
  output logic alarm_seen
);
  // ----------------------------------------------------------------
  // Loop state
  // ----------------------------------------------------------------
  // NC wiring opens the loop when the coil drops, so power loss alarms too
  assign alarm_seen = pol_nc ? !relay_energize : relay_energize;
endmodule : fsal_alarm_loop

// [verification/fsal_outputs_tb.sv]
/*
  Self-checking bench of fsal_outputs: read and probe tasks note expected values in a
  queue, a negedge monitor compares reads and output probes.
  Assumes shortened delay and power-up counts set below.
*/
`timescale 1ns/1ps
module fsal_outputs_tb;
  import fsal_pkg::*;
  localparam int unsigned D = 8;
  localparam int unsigned P = 16;
  logic clk_sys, sys_rst, ce, reg_wr, reg_rd, trip_event, fault_clear, run_mode;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [9:0] vref_input, freq_ref_in, freq_cmd, v, f_exp;
  logic [11:0] iref_input;
  logic oc_out1_n, oc_out2_n, relay_energize, decel_stop_req, irq, alarm_seen;
  logic pol_nc, probe, rd_prev;
  logic [31:0] exp_q[$];
  int fail_count, compares;

  fsal_outputs #(.ALARM_DELAY_CYC(D), .POWERUP_CYC(P)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trip_event(trip_event), .fault_clear(fault_clear), .run_mode(run_mode),
    .vref_input(vref_input), .iref_input(iref_input), .freq_ref_in(freq_ref_in),
    .oc_out1_n(oc_out1_n), .oc_out2_n(oc_out2_n), .relay_energize(relay_energize),
    .decel_stop_req(decel_stop_req), .freq_cmd(freq_cmd), .irq(irq));
  fsal_alarm_loop u_loop (.relay_energize(relay_energize), .pol_nc(pol_nc),
    .alarm_seen(alarm_seen));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Negedge sampling keeps clear of the design's own edge updates
  always @(negedge clk_sys) begin
    if (rd_prev) check(reg_rdata, exp_q.pop_front());
    if (probe) check({16'h0, freq_cmd, oc_out1_n, oc_out2_n, relay_energize, decel_stop_req,
      irq, alarm_seen}, exp_q.pop_front());
    rd_prev <= reg_rd;
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // Expected order: frequency, out1_n, out2_n, relay, stop request, irq
  task automatic look(input logic [4:0] e);
    exp_q.push_back({16'h0, f_exp, e, pol_nc ? ~e[2] : e[2]});
    @(posedge clk_sys);
    probe <= 1'b1;
    @(posedge clk_sys);
    probe <= 1'b0;
  endtask : look

  task automatic pulse(input bit trip);
    @(posedge clk_sys);
    if (trip) trip_event <= 1'b1;
    else fault_clear <= 1'b1;
    @(posedge clk_sys);
    trip_event <= 1'b0;
    fault_clear <= 1'b0;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #200_000;
    fail_count++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {reg_wr, reg_rd, trip_event, fault_clear, run_mode, probe, rd_prev} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    vref_input = 10'h3FF;
    iref_input = 12'h800;
    freq_ref_in = 10'h000;
    f_exp = 10'h000;
    pol_nc = 1'b1;
    void'($urandom(71));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    look(5'b11000);
    idle(8);
    look(5'b11000);
    idle(8);
    look(5'b11100);
    rd(OFF_CTRL, 32'h0001_5001);
    rd(OFF_START, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0);
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
    rd(OFF_STATUS, 32'h60);
    wr(OFF_CTRL, 32'h0001_5651);
    wr(OFF_IRQ_MASK, 32'h3);
    pulse(1);
    idle(5);
    look(5'b11101);
    idle(4);
    look(5'b01001);
    rd(OFF_STATUS, 32'h23);
    rd(OFF_IRQ_STAT, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    look(5'b01000);
    pulse(0);
    idle(12);
    look(5'b11100);
    // Trip shorter than the alarm delay must raise irq but not reach the alarm outputs
    pulse(1);
    idle(2);
    pulse(0);
    repeat (7) look(5'b11101);
    wr(OFF_IRQ_STAT, 32'h1);
    // Normally open wiring
    wr(OFF_CTRL, 32'h0001_5650);
    pol_nc <= 1'b0;
    idle(2);
    look(5'b11000);
    pulse(1);
    idle(12);
    look(5'b01101);
    pulse(0);
    idle(12);
    wr(OFF_IRQ_STAT, 32'h1);
    look(5'b11000);
    wr(OFF_CTRL, 32'h0001_5651);
    pol_nc <= 1'b1;
    // Input loss, stop mode first
    wr(OFF_START, 32'h64);
    vref_input <= 10'h063;
    idle(3);
    look(5'b10101);
    rd(OFF_STATUS, 32'h6C);
    run_mode <= 1'b1;
    idle(3);
    look(5'b10111);
    vref_input <= 10'h064;
    idle(3);
    look(5'b11101);
    rd(OFF_STATUS, 32'h60);
    iref_input <= 12'h332;
    idle(3);
    look(5'b10111);
    rd(OFF_STATUS, 32'h74);
    iref_input <= 12'h333;
    idle(3);
    look(5'b11101);
    wr(OFF_IRQ_MASK, 32'h1);
    idle(2);
    look(5'b11100);
    rd(OFF_IRQ_STAT, 32'h2);
    wr(OFF_IRQ_STAT, 32'h2);
    wr(OFF_IRQ_MASK, 32'h3);
    run_mode <= 1'b0;
    idle(2);
    look(5'b11100);
    // Frequency floor, zero and one first
    for (int i = 0; i < 8; i++) begin
      v = (i < 2) ? 10'(i) : 10'($urandom_range(1023, 0));
      f_exp = (v == 10'h000) ? 10'h000 : ((v < 10'h064) ? 10'h064 : v);
      freq_ref_in <= v;
      idle(2);
      rd(OFF_FREQ, {22'h0, f_exp});
      look(5'b11100);
    end
    // Clock enable low freezes every output and the loss detector
    ce <= 1'b0;
    vref_input <= 10'h063;
    idle(3);
    look(5'b11100);
    ce <= 1'b1;
    idle(3);
    look(5'b10101);
    idle(3);
    results();
  end
endmodule : fsal_outputs_tb
